// ### logic/adram_ctrl.sv
/*
  Host controller for one or more 64K x 8 asynchronous DRAM modules.
  Assumes modules share row strobe, address and write enable; column
  strobes are decoded per module; data pins combine by output enable.
*/
`timescale 1ns/100ps
module adram_ctrl #(
  parameter int MOD_CNT = 1,
  parameter int SEL_W = 1,
  parameter int PWRUP_CYCLES = adram_pkg::PWRUP_CYC,
  parameter int REF_INT_CYCLES = adram_pkg::REF_INT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_we_i,
  input wire logic [SEL_W-1:0] req_mod_i,
  input wire logic [adram_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [adram_pkg::DATA_W-1:0] req_wdata_i,
  output logic [adram_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic init_done_o,
  output logic ras_b_o,
  output logic [MOD_CNT-1:0] cas_b_o,
  output logic we_b_o,
  output logic [adram_pkg::ROW_W-1:0] muxed_address_pins_o,
  output logic [adram_pkg::DATA_W-1:0] shared_data_pins_o,
  output logic shared_data_pins_oe_b_o,
  input wire logic [adram_pkg::DATA_W-1:0] shared_data_pins_i
);
  import adram_pkg::*;

  adram_state_t st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic [TMR_W-1:0] ras_tmr_r, ras_tmr_nxt;
  logic [3:0] init_cnt_r, init_cnt_nxt;
  logic [TMR_W-1:0] ref_tmr_r, ref_tmr_nxt;
  logic ref_pend_r, ref_pend_nxt;
  logic [ROW_W-1:0] ref_row_r, ref_row_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic we_r, we_nxt;
  logic [SEL_W-1:0] mod_r, mod_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic ras_b_r, ras_b_nxt;
  logic cas_act_r, cas_act_nxt;
  logic we_b_r, we_b_nxt;
  logic [ROW_W-1:0] addr_r, addr_nxt;
  logic oe_b_r, oe_b_nxt;
  logic init_done_r, init_done_nxt;
  logic [DATA_W-1:0] dq_sync;
  logic tmr_done;
  logic ref_start;
  logic page_hit;
  logic take_idle;
  logic take_page;

  // Read data path through two flip-flops before use
  adram_sync #(.WIDTH(DATA_W)) u_dq_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(shared_data_pins_i),
    .sync_o(dq_sync)
  );

  assign tmr_done = (tmr_r == '0);
  // see RL14
  assign page_hit = (req_addr_i[ADDR_W-1:COL_W] == row_r) && !ref_pend_r
                    && (ras_tmr_r < TMR_W'(RAS_MAX_CYC));
  assign take_idle = (st_r == ST_IDLE) && !ref_pend_r && req_valid_i;
  assign take_page = (st_r == ST_CP) && tmr_done && page_hit && req_valid_i;
  assign ref_start = (st_r == ST_IDLE) && ref_pend_r;
  assign req_ready_o = ((st_r == ST_IDLE) && !ref_pend_r) || ((st_r == ST_CP) && tmr_done
                       && page_hit);

  // Refresh interval timer and row counter
  always_comb begin
    ref_tmr_nxt = ref_tmr_r;
    ref_pend_nxt = ref_pend_r;
    ref_row_nxt = ref_row_r;
    if (init_done_r) begin
      if (ref_start) begin
        ref_pend_nxt = 1'b0;
        ref_row_nxt = ref_row_r + 1'b1; // see RL19
      end
      if (ref_tmr_r == '0) begin
        ref_tmr_nxt = TMR_W'(REF_INT_CYCLES - 1);
        ref_pend_nxt = 1'b1; // see RL12
      end else begin
        ref_tmr_nxt = ref_tmr_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ref_tmr_r <= '0;
      ref_pend_r <= 1'b0;
      ref_row_r <= '0;
    end else begin
      ref_tmr_r <= ref_tmr_nxt;
      ref_pend_r <= ref_pend_nxt;
      ref_row_r <= ref_row_nxt;
    end
  end

  // Main sequencer
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_done ? tmr_r : tmr_r - 1'b1;
    ras_tmr_nxt = ras_b_r ? '0 : ras_tmr_r + 1'b1;
    init_cnt_nxt = init_cnt_r;
    init_done_nxt = init_done_r;
    row_nxt = row_r;
    col_nxt = col_r;
    we_nxt = we_r;
    mod_nxt = mod_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    ras_b_nxt = ras_b_r;
    cas_act_nxt = cas_act_r;
    we_b_nxt = we_b_r;
    addr_nxt = addr_r;
    oe_b_nxt = oe_b_r;
    if (take_idle || take_page) begin
      row_nxt = req_addr_i[ADDR_W-1:COL_W];
      col_nxt = req_addr_i[COL_W-1:0];
      we_nxt = req_we_i;
      mod_nxt = req_mod_i;
      wdata_nxt = req_wdata_i;
    end
    case (st_r)
      ST_PWR: begin
        ras_b_nxt = 1'b1; // see RL16
        if (tmr_done) begin
          st_nxt = ST_INIT_LO;
          ras_b_nxt = 1'b0;
          tmr_nxt = TMR_W'(RAS_CYC - 1);
        end
      end
      ST_INIT_LO: begin
        if (tmr_done) begin
          st_nxt = ST_INIT_HI;
          ras_b_nxt = 1'b1;
          tmr_nxt = TMR_W'(RP_CYC - 1);
          init_cnt_nxt = init_cnt_r + 1'b1;
        end
      end
      ST_INIT_HI: begin
        if (tmr_done) begin
          if (init_cnt_r == 4'(INIT_CYCLES)) begin // see RL16
            st_nxt = ST_IDLE;
            init_done_nxt = 1'b1;
          end else begin
            st_nxt = ST_INIT_LO;
            ras_b_nxt = 1'b0;
            tmr_nxt = TMR_W'(RAS_CYC - 1);
          end
        end
      end
      ST_IDLE: begin
        if (ref_pend_r) begin
          addr_nxt = ref_row_r; // see RL2
          st_nxt = ST_REF;
          tmr_nxt = TMR_W'(RAS_CYC);
        end else if (req_valid_i) begin
          addr_nxt = req_addr_i[ADDR_W-1:COL_W]; // see RL1
          st_nxt = ST_RCD;
          tmr_nxt = TMR_W'(RCD_CYC);
        end
      end
      ST_REF: begin
        ras_b_nxt = 1'b0; // see RL13
        if (tmr_done) begin
          st_nxt = ST_RP;
          ras_b_nxt = 1'b1;
          tmr_nxt = TMR_W'(RP_CYC - 1);
        end
      end
      ST_RCD: begin
        ras_b_nxt = 1'b0; // see RL1
        if (tmr_done && !ras_b_r) begin
          st_nxt = ST_COL;
          addr_nxt = col_r;
          we_b_nxt = !we_r; // see RL4
          oe_b_nxt = !we_r;
        end
      end
      ST_COL: begin
        // Write enable and data settle one cycle before the column strobe
        st_nxt = ST_CASL; // see RL6
        cas_act_nxt = 1'b1; // see RL8
        tmr_nxt = TMR_W'(CASL_CYC - 1);
      end
      ST_CASL: begin
        if (tmr_done) begin
          if (!we_r) begin
            rdata_nxt = dq_sync; // see RL10
            rvalid_nxt = 1'b1;
          end
          st_nxt = ST_CP;
          cas_act_nxt = 1'b0; // see RL11
          oe_b_nxt = 1'b1;
          we_b_nxt = 1'b1;
          tmr_nxt = TMR_W'(CP_CYC - 1);
        end
      end
      ST_CP: begin
        if (tmr_done) begin
          if (take_page) begin
            st_nxt = ST_COL; // see RL14
            addr_nxt = req_addr_i[COL_W-1:0];
            we_b_nxt = !req_we_i;
            oe_b_nxt = !req_we_i;
          end else begin
            st_nxt = ST_RP;
            ras_b_nxt = 1'b1;
            tmr_nxt = TMR_W'(RP_CYC - 1);
          end
        end
      end
      ST_RP: begin
        if (tmr_done) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_PWR;
        tmr_nxt = TMR_W'(PWRUP_CYCLES - 1);
        ras_b_nxt = 1'b1;
        cas_act_nxt = 1'b0;
        we_b_nxt = 1'b1;
        oe_b_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r <= ST_PWR;
      tmr_r <= TMR_W'(PWRUP_CYCLES - 1);
      ras_tmr_r <= '0;
      init_cnt_r <= '0;
      init_done_r <= 1'b0;
      row_r <= '0;
      col_r <= '0;
      we_r <= 1'b0;
      mod_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      ras_b_r <= 1'b1;
      cas_act_r <= 1'b0;
      we_b_r <= 1'b1;
      addr_r <= '0;
      oe_b_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      ras_tmr_r <= ras_tmr_nxt;
      init_cnt_r <= init_cnt_nxt;
      init_done_r <= init_done_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      we_r <= we_nxt;
      mod_r <= mod_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      ras_b_r <= ras_b_nxt;
      cas_act_r <= cas_act_nxt;
      we_b_r <= we_b_nxt;
      addr_r <= addr_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  // Decoded column strobes, one per module
  genvar gm;
  generate
    for (gm = 0; gm < MOD_CNT; gm++) begin : g_cas
      assign cas_b_o[gm] = !(cas_act_r && (mod_r == SEL_W'(gm))); // see RL15
    end
  endgenerate

  assign ras_b_o = ras_b_r;
  assign we_b_o = we_b_r;
  assign muxed_address_pins_o = addr_r;
  assign shared_data_pins_o = wdata_r; // see RL9
  assign shared_data_pins_oe_b_o = oe_b_r; // see RL7
  assign rdata_o = rdata_r;
  assign rdata_valid_o = rvalid_r;
  assign init_done_o = init_done_r;
endmodule

// ### logic/adram_pkg.sv
/*
  Constants for the host controller of a 64K x 8 asynchronous DRAM module.
  Assumes a 100 MHz system clock and early-write-only access on shared pins.
*/
// Operation
// RL1 - Row then column eight bits each
// RL2 - Address stable by each strobe falling edge
// RL3 - Device enables buffers only while column strobe low
// RL4 - Write enable high reads, low writes
// RL5 - Device ignores data pins during reads
// RL6 - Write enable low before column strobe falls
// RL7 - Device outputs float during early write
// RL8 - Column strobe edge captures early write data
// RL9 - Read data keeps written polarity
// RL10 - Read data valid after column access time
// RL11 - Outputs float when column strobe rises
// RL12 - All 256 rows strobed every 4 ms
// RL13 - Row-only refresh cycle, column strobe high
// RL14 - Page mode keeps row, pulses column strobe
// RL15 - Common row strobe, decoded column strobes
// RL16 - Power-up 100 us high, eight row cycles
// RL17 - Device latches address and data, not outputs
// RL18 - Eight one-bit chips form each byte
// RL19 - Refresh row counter interleaved with accesses
package adram_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ROW_W = 8;
  localparam int COL_W = 8;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam int DATA_W = 8;
  localparam int ROW_CNT = 256;
  localparam int INIT_CYCLES = 8;
  localparam int TMR_W = 16;

  localparam int T_RP_NS = 120;
  localparam int T_RAS_NS = 200;
  localparam int T_RAS_MAX_NS = 10000;
  localparam int T_CAS_NS = 135;
  localparam int T_CP_NS = 80;
  localparam int T_RCD_NS = 35;
  localparam int T_CAC_NS = 135;
  localparam int T_REF_MS = 4;
  localparam int T_PWRUP_US = 100;
  localparam int SYNC_STAGES = 2;

  // Least times round up
  localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_CYC = (T_CAS_NS * CLK_MHZ + 999) / 1000;
  localparam int CP_CYC = (T_CP_NS * CLK_MHZ + 999) / 1000;
  localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int CAC_CYC = (T_CAC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES + 1;
  localparam int CASL_CYC = (CAS_CYC > CAC_CYC) ? CAS_CYC : CAC_CYC;
  // Longest times round down
  localparam int RAS_MAX_CYC = (T_RAS_MAX_NS * CLK_MHZ) / 1000 - CASL_CYC - CP_CYC;
  localparam int REF_INT_CYC = (T_REF_MS * 1000 * CLK_MHZ) / ROW_CNT;
  localparam int PWRUP_CYC = T_PWRUP_US * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_PWR = 4'h0,
    ST_INIT_LO = 4'h1,
    ST_INIT_HI = 4'h3,
    ST_IDLE = 4'h2,
    ST_RCD = 4'h6,
    ST_COL = 4'h7,
    ST_CASL = 4'h5,
    ST_CP = 4'h4,
    ST_RP = 4'hC,
    ST_REF = 4'hD
  } adram_state_t;
endpackage

// ### logic/adram_sync.sv
/*
  Two-stage synchroniser for a bus of pin inputs.
  Assumes the pins are asynchronous to clk_i.
*/
`timescale 1ns/100ps
module adram_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import adram_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        meta_nxt[gi] = async_i[gi];
        sync_nxt[gi] = meta_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule

// ### dv/adram_ctrl_sva.sv
/* Pin checker for adram_ctrl.
   Assumes it is bound to every adram_ctrl and sees only its ports. */
`timescale 1ns/100ps
module adram_ctrl_sva #(
  parameter int MOD_CNT = 1,
  parameter int PWRUP_CYCLES = 20,
  parameter int REF_INT_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_ready_o,
  input wire logic init_done_o,
  input wire logic rdata_valid_o,
  input wire logic ras_b_o,
  input wire logic [MOD_CNT-1:0] cas_b_o,
  input wire logic we_b_o,
  input wire logic [adram_pkg::ROW_W-1:0] muxed_address_pins_o,
  input wire logic shared_data_pins_oe_b_o
);
  import adram_pkg::*;
  logic [31:0] up_r, up_nxt, gap_r, gap_nxt;
  wire cas_any = !(&cas_b_o);
  always_comb begin
    up_nxt = (up_r < PWRUP_CYCLES) ? up_r + 1 : up_r;
    gap_nxt = (!init_done_o || !ras_b_o) ? 0 : gap_r + 1;
  end
  always_ff @(posedge clk_i) begin
    up_r <= rst_b_i ? up_nxt : 0;
    gap_r <= rst_b_i ? gap_nxt : 0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_one_module: assert property ($countones(~cas_b_o) <= 1)
    else $error("two column strobes low");
  chk_col_in_row: assert property (cas_any |-> !ras_b_o)
    else $error("column strobe outside row");
  chk_row_addr: assert property ($fell(ras_b_o) |-> $stable(muxed_address_pins_o))
    else $error("row address moved at row strobe");
  chk_col_addr: assert property (cas_any && $past(cas_any) |-> $stable(muxed_address_pins_o))
    else $error("column address moved");
  chk_early_write: assert property ($rose(cas_any) |-> $stable(we_b_o))
    else $error("write enable moved at column strobe");
  chk_drive_write: assert property (!shared_data_pins_oe_b_o |-> !we_b_o)
    else $error("data driven in read");
  chk_write_data: assert property (cas_any && !we_b_o |-> !shared_data_pins_oe_b_o)
    else $error("write data not driven");
  chk_no_early_req: assert property (!init_done_o |-> !req_ready_o)
    else $error("request taken before init");
  chk_pwrup_quiet: assert property (up_r < PWRUP_CYCLES |-> ras_b_o && !init_done_o)
    else $error("row strobe in power-up wait");
  chk_refresh_gap: assert property (gap_r <= REF_INT_CYCLES + 20)
    else $error("refresh overdue");
  chk_read_closed: assert property (rdata_valid_o |-> !cas_any)
    else $error("read data before strobe release");
  cover property (cas_any && !we_b_o);
  cover property (rdata_valid_o);
  cover property ((!ras_b_o) throughout ($rose(cas_any) ##[2:40] $rose(cas_any)));
endmodule
bind adram_ctrl adram_ctrl_sva #(.MOD_CNT(MOD_CNT), .PWRUP_CYCLES(PWRUP_CYCLES),
  .REF_INT_CYCLES(REF_INT_CYCLES)) u_adram_ctrl_sva (.clk_i, .rst_b_i, .req_ready_o,
  .init_done_o, .rdata_valid_o, .ras_b_o, .cas_b_o, .we_b_o, .muxed_address_pins_o,
  .shared_data_pins_oe_b_o);

// ### dv/adram_dev.sv
/* Behavioural model of one 64K x 8 module of eight one-bit chips.
   Assumes the bench resolves dq_o against other drivers by dq_oe_b_o. */
`timescale 1ns/100ps
module adram_dev #(
  parameter real T_CAC = 135.0
) (
  input wire logic ras_b_i,
  input wire logic cas_b_i,
  input wire logic we_b_i,
  input wire logic [adram_pkg::ROW_W-1:0] addr_i,
  input wire logic [adram_pkg::DATA_W-1:0] dq_i,
  output logic [adram_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_b_o
);
  import adram_pkg::*;
  logic [DATA_W-1:0] mem [0:65535];
  logic [ROW_W-1:0] row, col;
  initial dq_oe_b_o = 1'b1;
  initial dq_o = '0;
  always @(negedge ras_b_i) row = addr_i;
  always @(negedge cas_b_i) begin
    col = addr_i;
    if (!we_b_i) begin
      mem[{row, col}] = dq_i;
    end else begin
      #(T_CAC);
      if (!cas_b_i && we_b_i) begin
        dq_o = mem[{row, col}];
        dq_oe_b_o = 1'b0;
      end
    end
  end
  always @(posedge cas_b_i) dq_oe_b_o = 1'b1;
endmodule

// ### dv/adram_ctrl_test.sv
/* Self-checking bench for adram_ctrl driving two modules.
   Assumes adram_dev as far side; data pins are resolved here. */
`timescale 1ns/100ps
module adram_ctrl_test;
  import adram_pkg::*;
  localparam int PW = 20;
  localparam int RI = 200;
  typedef struct packed {logic we; logic m; logic [15:0] a; logic [7:0] d;} adram_row_t;
  logic clk_i, rst_b_i, req_valid_i, req_we_i, req_ready_o, rdata_valid_o, init_done_o;
  logic ras_b_o, we_b_o, oe_b, e0, e1, cas_seen;
  logic [0:0] req_mod_i;
  logic [1:0] cas_b_o;
  logic [ADDR_W-1:0] req_addr_i;
  logic [DATA_W-1:0] req_wdata_i, rdata_o, ctrl_dq, dq, dq_last, d0, d1, got;
  logic [ROW_W-1:0] addr, row_seen, ref_prev;
  int mismatches, tests_run, cyc, ref_cnt, ras_cnt;
  adram_row_t rows [10] = '{
    '{1'b1, 1'b0, 16'h0000, 8'hA5}, '{1'b1, 1'b0, 16'hFFFF, 8'h5A},
    '{1'b1, 1'b1, 16'h0000, 8'h3C}, '{1'b1, 1'b0, 16'h1235, 8'hFF},
    '{1'b1, 1'b0, 16'h1234, 8'h00}, '{1'b0, 1'b0, 16'h0000, 8'hA5},
    '{1'b0, 1'b1, 16'h0000, 8'h3C}, '{1'b0, 1'b0, 16'hFFFF, 8'h5A},
    '{1'b0, 1'b0, 16'h1234, 8'h00}, '{1'b0, 1'b0, 16'h1235, 8'hFF}};
  adram_ctrl #(.MOD_CNT(2), .SEL_W(1), .PWRUP_CYCLES(PW), .REF_INT_CYCLES(RI)) u_adram_ctrl (
    .clk_i, .rst_b_i, .req_valid_i, .req_ready_o, .req_we_i, .req_mod_i, .req_addr_i,
    .req_wdata_i, .rdata_o, .rdata_valid_o, .init_done_o, .ras_b_o, .cas_b_o, .we_b_o,
    .muxed_address_pins_o(addr), .shared_data_pins_o(ctrl_dq),
    .shared_data_pins_oe_b_o(oe_b), .shared_data_pins_i(dq));
  adram_dev u_adram_dev [1:0] (.ras_b_i(ras_b_o), .cas_b_i(cas_b_o), .we_b_i(we_b_o),
    .addr_i(addr), .dq_i(dq), .dq_o({d1, d0}), .dq_oe_b_o({e1, e0}));
  // Undriven pins show the inverse of the last driven value
  assign dq = !e0 ? d0 : !e1 ? d1 : !oe_b ? ctrl_dq : ~dq_last;
  always @(posedge clk_i) if (!(e0 && e1 && oe_b)) dq_last <= dq;
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic access(input adram_row_t r);
    int n;
    @(posedge clk_i);
    #1 req_valid_i = 1;
    req_we_i = r.we;
    req_mod_i = r.m;
    req_addr_i = r.a;
    req_wdata_i = r.d;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_i);
      if (req_ready_o === 1'b1) break;
    end
    #1 req_valid_i = 0;
    check("taken", n < 3000, 1);
    if (!r.we) begin
      for (n = 0; n < 200; n++) begin
        @(posedge clk_i);
        if (rdata_valid_o === 1'b1) break;
      end
      check("rdata_valid", n < 200, 1);
      check("rdata", rdata_o, r.d);
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("Error timeout expected done seen hang");
      end_sim;
    end
  end
  always @(negedge ras_b_o) begin
    row_seen = addr;
    cas_seen = 0;
  end
  always @(negedge cas_b_o[0] or negedge cas_b_o[1]) cas_seen = 1;
  always @(posedge ras_b_o) begin
    if (!init_done_o) ras_cnt++;
    else if (!cas_seen) begin
      if (ref_cnt > 0) check("refresh_row", row_seen, ROW_W'(ref_prev + 8'h01));
      ref_prev = row_seen;
      ref_cnt++;
    end
  end
  initial begin
    rst_b_i = 0;
    req_valid_i = 0;
    req_we_i = 0;
    req_mod_i = 0;
    req_addr_i = 0;
    req_wdata_i = 0;
    dq_last = 0;
    mismatches = 0;
    tests_run = 0;
    cyc = 0;
    ref_cnt = 0;
    ref_prev = 0;
    repeat (8) @(posedge clk_i);
    ras_cnt = 0;
    #1 rst_b_i = 1;
    foreach (rows[i]) access(rows[i]);
    check("init_cycles", ras_cnt, 8);
    $display("table done");
    repeat (3 * RI) @(posedge clk_i);
    check("refresh_seen", ref_cnt >= 2, 1);
    $display("refresh done");
    #1 rst_b_i = 0;
    @(posedge clk_i);
    #1 check("reset_pins", {ras_b_o, cas_b_o, we_b_o, oe_b, init_done_o, req_ready_o,
      rdata_valid_o}, 8'hF8);
    repeat (7) @(posedge clk_i);
    ras_cnt = 0;
    ref_cnt = 0;
    #1 rst_b_i = 1;
    access(rows[9]);
    check("reinit_cycles", ras_cnt, 8);
    $display("reset done");
    end_sim;
  end
endmodule
